// *** logic/sbsc_burst_ctr.sv ***
/*
 * two-bit burst address counter with load, step and hold
 * assumes load and step never rise together (top priority-decodes them)
 */
`timescale 1ns/100ps
`default_nettype none

module sbsc_burst_ctr
    import sbsc_pkg::*;
#(
    parameter int AW = SBSC_ADDR_W
)(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // link
    sbsc_link_if.ctr  lnk
);

    logic [AW-1:0] addr_q,  addr_d;
    logic [1:0]    start_q, start_d;
    logic [1:0]    cnt_q,   cnt_d;

    always_comb
    begin
        addr_d  = addr_q;
        start_d = start_q;
        cnt_d   = cnt_q;
        if (lnk.load)
        begin
            addr_d  = lnk.ext_addr;
            start_d = lnk.ext_addr[1:0];
            cnt_d   = 2'h0;
        end
        else if (lnk.step)
        begin
            // wraps mod four, so the fifth beat is the start again
            cnt_d = 2'(cnt_q + 2'h1);
            if (!lnk.linear_n)
                addr_d[1:0] = 2'(start_q + cnt_d);
            else
                addr_d[1:0] = start_q ^ cnt_d;
            // upper bits untouched
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_q  <= '0;
            start_q <= 2'h0;
            cnt_q   <= 2'h0;
        end
        else
        begin
            addr_q  <= addr_d;
            start_q <= start_d;
            cnt_q   <= cnt_d;
        end
    end

    assign lnk.cur_addr = addr_q;

endmodule

`default_nettype wire

// *** logic/sbsc_link_if.sv ***
/*
 * carrier between the control top, burst counter and write decoder
 * assumes all three sit on pclk
 */
`timescale 1ns/100ps
`default_nettype none

interface sbsc_link_if #(
    parameter int AW    = 20,
    parameter int LANES = 2
);
    logic             load;
    logic             step;
    logic             linear_n;
    logic [AW-1:0]    ext_addr;
    logic [AW-1:0]    cur_addr;
    logic             global_write_n;
    logic             byte_write_gate_n;
    logic [LANES-1:0] lane_write_n;
    logic             is_write;
    logic [LANES-1:0] lanes_wr;

    modport top (output load, step, linear_n, ext_addr, global_write_n,
                 byte_write_gate_n, lane_write_n, input cur_addr, is_write, lanes_wr);
    modport ctr (input load, step, linear_n, ext_addr, output cur_addr);
    modport dec (input global_write_n, byte_write_gate_n, lane_write_n,
                 output is_write, lanes_wr);
endinterface

`default_nettype wire

// *** logic/sbsc_pkg.sv ***
/*
 * constants and types shared by the burst sram control block
 * assumes a single clock domain (pclk) and an apb master on the register side
 */
//
// Overview of operation
// - interleaved: start low bits xor beat count
// - order select low means linear upward count
// - read when no lane writes; all lanes drive
// - byte gate low writes only enabled lanes
// - global write low writes every lane
// - data pins float during every write
// - upper two lanes only in wide build
// - output enable high kills drivers at once
// - chip disabled with ctrl strobe: deselect
// - proc strobe with chip enabled: read load
// - ctrl strobe loads address, write decode
// - no strobe, advance low: next address
// - no strobe, advance high: hold address
// - dummy read steps counter like read
// - flow select low bypasses output register
`default_nettype none

package sbsc_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0]  SBSC_CTRL_OFS   = 8'h00;
    localparam logic [7:0]  SBSC_STATUS_OFS = 8'h04;
    localparam logic [7:0]  SBSC_COUNT_OFS  = 8'h08;
    localparam int          SBSC_CTRL_EN_BIT = 0;
    localparam logic [31:0] SBSC_CTRL_RST   = 32'h0000_0001;
    localparam logic [31:0] SBSC_COUNT_RST  = 32'h0000_0000;

    // ************************************************************
    // geometry defaults
    // ************************************************************
    localparam int SBSC_ADDR_W = 20;
    localparam int SBSC_LANES  = 2;
    localparam int SBSC_LANE_W = 9;

    // ************************************************************
    // last cycle kind, gray along desel, read, write
    // ************************************************************
    typedef enum logic [1:0] {
        SBSC_DESEL = 2'b00,
        SBSC_READ  = 2'b01,
        SBSC_WRITE = 2'b11
    } sbsc_op_t;

endpackage

`default_nettype wire

// *** logic/sbsc_top.sv ***
/*
 * synchronous burst sram control: command decode, burst addressing,
 * byte-write strobes, read output staging and an apb status port
 * assumes the array reads combinationally from mem_addr while mem_rd is high,
 * and that the controller idles the bus before turning reads into writes
 */
`timescale 1ns/100ps
`default_nettype none

module sbsc_top
    import sbsc_pkg::*;
#(
    parameter int AW     = SBSC_ADDR_W,
    parameter int LANES  = SBSC_LANES, // 4 only in the wide build
    parameter int LANE_W = SBSC_LANE_W
)(
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // sram command pins
    input  wire logic                    chip_enable_n,
    input  wire logic                    proc_addr_strobe_n,
    input  wire logic                    ctrl_addr_strobe_n,
    input  wire logic                    burst_advance_n,
    input  wire logic                    global_write_n,
    input  wire logic                    byte_write_gate_n,
    input  wire logic [LANES-1:0]        lane_write_n,
    input  wire logic                    out_enable_n,
    input  wire logic                    linear_order_sel_n,
    input  wire logic                    flow_through_sel_n,
    input  wire logic [AW-1:0]           addr,
    // data pins
    input  wire logic [LANES*LANE_W-1:0] dq_in,
    output logic [LANES*LANE_W-1:0]      dq_out,
    output logic [LANES-1:0]             dq_oe_n,
    // array side
    output logic [AW-1:0]                mem_addr,
    output logic                         mem_rd,
    output logic [LANES-1:0]             mem_wr_lanes,
    output logic [LANES*LANE_W-1:0]      mem_wdata,
    input  wire logic [LANES*LANE_W-1:0] mem_rdata
);

    localparam int DW = LANES * LANE_W;

    sbsc_link_if #(.AW(AW), .LANES(LANES)) lnk ();

    sbsc_burst_ctr #(.AW(AW)) u_ctr (
        .pclk    (pclk),
        .presetn (presetn),
        .lnk     (lnk)
    );

    sbsc_write_dec #(.LANES(LANES)) u_dec (
        .lnk (lnk)
    );

    // ************************************************************
    // command decode
    // ************************************************************
    logic     enable_q, enable_d;
    logic     cmd_load, cmd_step, cmd_access, cmd_write;

    always_comb
    begin
        cmd_load   = 1'b0;
        cmd_step   = 1'b0;
        cmd_access = 1'b0;
        cmd_write  = 1'b0;
        if (!enable_q)
        begin
            cmd_access = 1'b0;
        end
        else if (!chip_enable_n && !proc_addr_strobe_n)
        begin
            cmd_load   = 1'b1; // read, other strobes ignored
            cmd_access = 1'b1;
        end
        else if (!chip_enable_n && !ctrl_addr_strobe_n)
        begin
            cmd_load   = 1'b1;
            cmd_access = 1'b1;
            cmd_write  = lnk.is_write;
        end
        else if (!ctrl_addr_strobe_n)
        begin
            cmd_access = 1'b0; // deselect, no address used
        end
        else
        begin
            // dummy reads step too: out_enable_n is not looked at
            cmd_step   = !burst_advance_n;
            cmd_access = 1'b1; // hold when advance high
            cmd_write  = lnk.is_write;
        end
    end

    assign lnk.load              = cmd_load;
    assign lnk.step              = cmd_step;
    assign lnk.linear_n          = linear_order_sel_n;
    assign lnk.ext_addr          = addr;
    assign lnk.global_write_n    = global_write_n;
    assign lnk.byte_write_gate_n = byte_write_gate_n;
    assign lnk.lane_write_n      = lane_write_n;

    // ************************************************************
    // array strobes, registered one cycle after the command edge
    // ************************************************************
    logic             rd_q,    rd_d;
    logic [LANES-1:0] wr_q,    wr_d;
    logic [DW-1:0]    wdata_q, wdata_d;
    sbsc_op_t         op_q,    op_d;

    always_comb
    begin
        rd_d    = cmd_access && !cmd_write;
        wr_d    = cmd_write ? lnk.lanes_wr : '0;
        wdata_d = cmd_write ? dq_in : wdata_q;
        case ({cmd_access, cmd_write})
            2'b10:   op_d = SBSC_READ;
            2'b11:   op_d = SBSC_WRITE;
            default: op_d = SBSC_DESEL;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_q    <= 1'b0;
            wr_q    <= '0;
            wdata_q <= '0;
            op_q    <= SBSC_DESEL;
        end
        else
        begin
            rd_q    <= rd_d;
            wr_q    <= wr_d;
            wdata_q <= wdata_d;
            op_q    <= op_d;
        end
    end

    assign mem_addr     = lnk.cur_addr;
    assign mem_rd       = rd_q;
    assign mem_wr_lanes = wr_q;
    assign mem_wdata    = wdata_q;

    // ************************************************************
    // access counter
    // ************************************************************
    // wraps at the top; software must read it often enough
    logic [31:0] count_q, count_d;

    always_comb
    begin
        count_d = count_q;
        if (cmd_access)
            count_d = 32'(count_q + 32'h1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_q <= SBSC_COUNT_RST;
        else
            count_q <= count_d;
    end

    // ************************************************************
    // read output staging
    // ************************************************************
    // stage one is the output register that the flow-through path skips, stage two drives the pins
    logic          s1_vld_q, s1_vld_d;
    logic [DW-1:0] s1_dat_q, s1_dat_d;
    logic          s2_vld_q, s2_vld_d;
    logic          drive_q,  drive_d;
    logic [DW-1:0] out_q,    out_d;
    logic          wr_now;

    always_comb
    begin
        wr_now   = |wr_d;
        s1_vld_d = rd_q;
        s1_dat_d = rd_q ? mem_rdata : s1_dat_q;
        s2_vld_d = s1_vld_q && !wr_now;
        if (!flow_through_sel_n)
        begin
            drive_d = rd_q && !wr_now;
            out_d   = rd_q ? mem_rdata : out_q;
        end
        else
        begin
            drive_d = s1_vld_q && !wr_now;
            out_d   = s1_vld_q ? s1_dat_q : out_q;
        end
        // a write cycle never leaves a driver on
        if (|wr_q)
            drive_d = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_vld_q <= 1'b0;
            s1_dat_q <= '0;
            s2_vld_q <= 1'b0;
            drive_q  <= 1'b0;
            out_q    <= '0;
        end
        else
        begin
            s1_vld_q <= s1_vld_d;
            s1_dat_q <= s1_dat_d;
            s2_vld_q <= s2_vld_d;
            drive_q  <= drive_d;
            out_q    <= out_d;
        end
    end

    assign dq_out = out_q;
    // enable must bypass the clock, so this is the one gated output
    assign dq_oe_n = {LANES{!drive_q || out_enable_n}}; // all lanes together

    // ************************************************************
    // apb slave
    // ************************************************************
    logic        pready_q,  pready_d;
    logic        pslverr_q, pslverr_d;
    logic [31:0] prdata_q,  prdata_d;
    logic        setup;
    logic        hit;
    logic [31:0] rval;

    always_comb
    begin
        setup = psel && !penable && !pready_q;
        hit   = 1'b1;
        rval  = 32'h0;
        case (paddr)
            SBSC_CTRL_OFS:   rval = {31'h0, enable_q};
            SBSC_STATUS_OFS: rval = {24'h0, s2_vld_q, drive_q, op_q, 2'h0,
                                     lnk.cur_addr[1:0]};
            SBSC_COUNT_OFS:  rval = count_q;
            default:         hit  = 1'b0;
        endcase
        pready_d  = setup;
        pslverr_d = setup && !hit;
        prdata_d  = (setup && !pwrite) ? rval : 32'h0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end
        else
        begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    // ************************************************************
    // control register
    // ************************************************************
    // a write lands at the access edge only, never at setup
    always_comb
    begin
        enable_d = enable_q;
        if (psel && penable && pready_q && pwrite && paddr == SBSC_CTRL_OFS)
            enable_d = pwdata[SBSC_CTRL_EN_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            enable_q <= SBSC_CTRL_RST[SBSC_CTRL_EN_BIT];
        else
            enable_q <= enable_d;
    end

    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign prdata  = prdata_q;

endmodule

`default_nettype wire

// *** logic/sbsc_write_dec.sv ***
/*
 * byte-write decode: global write, byte gate and lane enables
 * assumes synchronous inputs; purely combinational
 */
`timescale 1ns/100ps
`default_nettype none

module sbsc_write_dec
    import sbsc_pkg::*;
#(
    parameter int LANES = SBSC_LANES
)(
    sbsc_link_if.dec lnk
);

    logic [LANES-1:0] lanes;

    // ************************************************************
    // per-lane strobes
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            // global write overrides gate and lanes
            assign lanes[g] = !lnk.global_write_n
                           || (!lnk.byte_write_gate_n && !lnk.lane_write_n[g]);
        end
    endgenerate

    assign lnk.lanes_wr = lanes;
    assign lnk.is_write = |lanes;

endmodule

`default_nettype wire

// *** sim/sbsc_mem_model.sv ***
/* array model on the far side of the control block
   assumes data is looked at only while mem_rd is high */
`timescale 1ns/100ps
`default_nettype none
module sbsc_mem_model #(parameter int AW = 20, parameter int LW = 9)(
    // clock and array port
    input wire logic pclk, mem_rd,
    input wire logic [AW-1:0] mem_addr,
    input wire logic [1:0] mem_wr_lanes,
    input wire logic [2*LW-1:0] mem_wdata,
    output logic [2*LW-1:0] mem_rdata
);
    logic [2*LW-1:0] ram [16];
    logic [2*LW-1:0] last = '0;
    // idle bus shows the inverse, so stale data never passes
    assign mem_rdata = mem_rd ? ram[mem_addr[3:0]] : ~last;
    always @(posedge pclk)
    begin
        if (mem_rd) last <= ram[mem_addr[3:0]];
        for (int i = 0; i < 2; i++)
            if (mem_wr_lanes[i]) ram[mem_addr[3:0]][i*LW +: LW] <= mem_wdata[i*LW +: LW];
    end
endmodule
`default_nettype wire

// *** sim/sbsc_top_sva.sv ***
/* checker for the burst sram control top
   assumes it is bound onto sbsc_top, one clock domain */
`timescale 1ns/100ps
`default_nettype none
module sbsc_top_sva #(parameter int AW = 20, parameter int LANES = 2)(
    // clock, reset and command pins
    input wire logic pclk, presetn, chip_enable_n, proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n, burst_advance_n, global_write_n,
    input wire logic byte_write_gate_n, out_enable_n, linear_order_sel_n,
    input wire logic [AW-1:0] addr,
    // lane enables and outputs watched
    input wire logic [LANES-1:0] lane_write_n, dq_oe_n, mem_wr_lanes,
    input wire logic [AW-1:0] mem_addr,
    input wire logic mem_rd
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ********
    // command classes
    // ********
    wire logic ld_p  = !chip_enable_n && !proc_addr_strobe_n;
    wire logic desel = chip_enable_n && !ctrl_addr_strobe_n;
    wire logic acc   = !desel && !ld_p;
    wire logic cont  = ctrl_addr_strobe_n && (proc_addr_strobe_n || chip_enable_n);
    // counter only meaningful after a real access
    wire logic live  = mem_rd || (|mem_wr_lanes);
    property p_desel; desel |=> !mem_rd && mem_wr_lanes == '0; endproperty
    a_desel: assert property (p_desel) else $error("access after deselect");
    property p_pload; ld_p |=> mem_rd && mem_wr_lanes == '0 && mem_addr == $past(addr);
    endproperty
    a_pload: assert property (p_pload) else $error("bad strobe load");
    property p_gw; acc && !global_write_n |=> &mem_wr_lanes && !mem_rd; endproperty
    a_gw: assert property (p_gw) else $error("global write lanes");
    property p_bw; acc && global_write_n && !byte_write_gate_n
        |=> mem_wr_lanes == ~$past(lane_write_n); endproperty
    a_bw: assert property (p_bw) else $error("byte write lanes");
    property p_rd; acc && global_write_n && byte_write_gate_n |=> mem_rd; endproperty
    a_rd: assert property (p_rd) else $error("read not issued");
    property p_step; cont && !burst_advance_n && !linear_order_sel_n && live
        |=> mem_addr == {$past(mem_addr[AW-1:2]), $past(mem_addr[1:0]) + 2'h1}; endproperty
    a_step: assert property (p_step) else $error("linear step");
    property p_hold; cont && burst_advance_n && live |=> $stable(mem_addr); endproperty
    a_hold: assert property (p_hold) else $error("suspend moved");
    property p_wfloat; |mem_wr_lanes |-> &dq_oe_n; endproperty
    a_wfloat: assert property (p_wfloat) else $error("driving in write");
    property p_oe; out_enable_n |-> &dq_oe_n; endproperty
    a_oe: assert property (p_oe) else $error("drive with oe off");
endmodule
`default_nettype wire

// *** sim/test_sync_burst_sram_control.sv ***
/* bench for the burst sram control top with the array model
   assumes package, design, model and checker compiled first */
`timescale 1ns/100ps
`default_nettype none
module test_sync_burst_sram_control
    import sbsc_pkg::*;
;
    localparam int DW = SBSC_LANES * SBSC_LANE_W;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    // idle pins deselect, so no access is counted before the scenarios
    logic chip_enable_n = 1'b1, proc_addr_strobe_n = 1'b1, ctrl_addr_strobe_n = 1'b0;
    logic burst_advance_n = 1'b1, global_write_n = 1'b1, byte_write_gate_n = 1'b1;
    logic out_enable_n = 1'b0, linear_order_sel_n = 1'b1, flow_through_sel_n = 1'b1;
    logic [1:0] lane_write_n = 2'h3, dq_oe_n, mem_wr_lanes, s_wr, s_oe;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, mem_rd, s_rd;
    logic [19:0] addr = 20'h0, mem_addr, s_addr;
    logic [DW-1:0] dq_in = '0, dq_out, mem_wdata, mem_rdata, s_dq, s_wd;
    int err_count = 0, checks_done = 0;
    sbsc_top dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chip_enable_n(chip_enable_n), .proc_addr_strobe_n(proc_addr_strobe_n),
        .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .burst_advance_n(burst_advance_n),
        .global_write_n(global_write_n), .byte_write_gate_n(byte_write_gate_n),
        .lane_write_n(lane_write_n), .out_enable_n(out_enable_n),
        .linear_order_sel_n(linear_order_sel_n), .flow_through_sel_n(flow_through_sel_n),
        .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr_lanes(mem_wr_lanes),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    sbsc_mem_model mem_u (.pclk(pclk), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_wr_lanes(mem_wr_lanes), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    initial forever #12.5 pclk = ~pclk;
    // ********
    // shared tasks
    // ********
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task timeout;
        err_count++;
        $display("mismatch at %0t: wait ran out", $time);
        complete_run();
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) timeout();
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    // c = ce, proc, ctrl, advance; w = global, gate, lanes; snapshot is the previous command
    task cmd(input logic [3:0] c, input logic [3:0] w, input logic [19:0] a);
        {chip_enable_n, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} <= c;
        {global_write_n, byte_write_gate_n, lane_write_n} <= w;
        addr <= a;
        @(negedge pclk);
        {s_addr, s_rd, s_wr, s_oe, s_dq, s_wd} =
            {mem_addr, mem_rd, mem_wr_lanes, dq_oe_n, dq_out, mem_wdata};
        @(posedge pclk);
    endtask
    // ********
    // scenarios
    // ********
    task t_regs;
        logic [31:0] r;
        logic e;
        apb(1'b0, SBSC_CTRL_OFS, 32'h0, r, e);
        chk(r, SBSC_CTRL_RST);
        apb(1'b0, SBSC_COUNT_OFS, 32'h0, r, e);
        chk(r, SBSC_COUNT_RST);
        apb(1'b0, 8'h10, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        apb(1'b1, SBSC_CTRL_OFS, 32'h0, r, e);
        apb(1'b0, SBSC_CTRL_OFS, 32'h0, r, e);
        chk({r[30:0], e}, 32'h0);
        apb(1'b1, SBSC_CTRL_OFS, 32'h1, r, e);
        apb(1'b0, SBSC_CTRL_OFS, 32'h0, r, e);
        chk({r[30:0], e}, 32'h2);
    endtask
    task t_write;
        logic [3:0] w;
        logic [1:0] x;
        for (int i = 0; i < 6; i++)
        begin
            w = i < 4 ? {2'b10, i[1:0]} : (i == 4 ? 4'b0111 : 4'b1111);
            x = i < 4 ? ~i[1:0] : (i == 4 ? 2'h3 : 2'h0);
            dq_in <= 18'h2d4b3 ^ 18'(i);
            cmd(4'b0101, w, 20'h00010 + 20'(i));
            cmd(4'b1101, 4'b1111, 20'h0);
            chk(s_wr, x);
            chk(s_rd, i == 3 || i == 5);
            if (x != 2'h0) chk({s_oe, s_wd}, {2'h3, 18'h2d4b3 ^ 18'(i)});
        end
        cmd(4'b0101, 4'b0111, 20'h00014);
        cmd(4'b0111, 4'b0111, 20'h0);
        cmd(4'b1010, 4'b0111, 20'h0);
        chk({s_addr, s_wr}, {20'h00014, 2'h3});
        cmd(4'b1101, 4'b1111, 20'h0);
        chk({s_addr, s_wr}, {20'h00015, 2'h3});
    endtask
    task t_burst;
        logic [1:0] e;
        for (int o = 0; o < 2; o++)
            for (int s = 0; s < 4; s++)
            begin
                linear_order_sel_n <= o[0];
                cmd(4'b0011, 4'b1111, 20'h5a5a8 + 20'(s));
                for (int k = 0; k < 5; k++)
                begin
                    cmd(k[0] ? 4'b1010 : 4'b0110, 4'b1111, 20'hfffff);
                    e = o[0] ? s[1:0] ^ k[1:0] : s[1:0] + k[1:0];
                    chk(s_addr, 20'h5a5a8 + 20'(e));
                end
            end
        cmd(4'b1101, 4'b1111, 20'h0);
    endtask
    task t_read(input logic ft, output int n);
        logic [DW-1:0] d;
        d = 18'h1c3a5 ^ 18'(ft);
        flow_through_sel_n <= ft;
        dq_in <= d;
        cmd(4'b0101, 4'b0111, 20'h00009);
        cmd(4'b0011, 4'b0000, 20'h00009);
        n = 0;
        do
        begin
            cmd(4'b0111, 4'b1111, 20'h0);
            n++;
        end
        while (s_oe !== 2'h0 && n < 8);
        if (s_oe !== 2'h0) timeout();
        chk(s_dq, d);
        out_enable_n <= 1'b1;
        cmd(4'b0111, 4'b1111, 20'h0);
        chk(s_oe, 2'h3);
        cmd(4'b0110, 4'b1111, 20'h0);
        cmd(4'b0110, 4'b1111, 20'h0);
        chk({s_addr, s_rd, s_oe}, {20'h00008, 3'h7});
        cmd(4'b0101, 4'b0111, 20'h00009);
        cmd(4'b1101, 4'b1111, 20'h0);
        chk(s_wr, 2'h3);
        out_enable_n <= 1'b0;
    endtask
    initial
    begin
        int nf, np;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_write();
        t_burst();
        t_read(1'b0, nf);
        t_read(1'b1, np);
        chk(np, nf + 1);
        complete_run();
    end
endmodule
bind sbsc_top sbsc_top_sva #(.AW(AW), .LANES(LANES)) sva_u (
    .pclk(pclk), .presetn(presetn), .chip_enable_n(chip_enable_n),
    .proc_addr_strobe_n(proc_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
    .burst_advance_n(burst_advance_n), .global_write_n(global_write_n),
    .byte_write_gate_n(byte_write_gate_n), .out_enable_n(out_enable_n),
    .linear_order_sel_n(linear_order_sel_n), .addr(addr), .lane_write_n(lane_write_n),
    .dq_oe_n(dq_oe_n), .mem_wr_lanes(mem_wr_lanes), .mem_addr(mem_addr), .mem_rd(mem_rd));
`default_nettype wire
